// ### tb_top.sv
// Self-checking testbench of the watchdog interval timer
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import wdt_pkg::*;
;
	logic clock;
	logic rst_n;
	logic hsel;
	logic hwrite;
	logic debug_acknowledge;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout;
	logic hresp;
	logic sys_reset;
	logic timer_irq_pulse;
	logic irq;
	logic [31:0] rd;
	int error_cnt = 0;
	int n_compared = 0;
	int n;

	wdt_top dut_u (
		.clock(clock),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.debug_acknowledge(debug_acknowledge),
		.sys_reset(sys_reset),
		.timer_irq_pulse(timer_irq_pulse),
		.irq(irq)
	);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	// ----------------
	// Helpers
	// ----------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// Address phase held until hready, then data phase until hready again
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'h1);
		rd = hrdata;
		chk({30'h0, hreadyout, hresp}, 32'h2);
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'h1, d);
	endtask

	task rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'h0, 32'h0);
		chk(rd, exp);
	endtask

	task wait_pulse;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (timer_irq_pulse !== 1'h1 && n < 5000);
		if (n >= 5000) begin
			$display("CHECK FAILED %0t: no interrupt pulse", $time);
			error_cnt++;
		end
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task t_reset_vals;
		rdchk(WDT_COUNT_ADDR, 32'h8000);
		rdchk(WDT_CTRL_ADDR, 32'h8021);
		rdchk(WDT_RELOAD_ADDR, 32'h8000);
		rdchk(WDT_IRQ_STAT_ADDR, 32'h0);
		rdchk(WDT_IRQ_MASK_ADDR, 32'h0);
	endtask

	task t_regs;
		wr(WDT_CTRL_ADDR, 32'hFF3D);
		rdchk(WDT_CTRL_ADDR, 32'hFF3D);
		wr(WDT_CTRL_ADDR, 32'h0);
		wr(WDT_RELOAD_ADDR, 32'hA5C3);
		rdchk(WDT_RELOAD_ADDR, 32'hA5C3);
		wr(32'h5300_0020, 32'hFFFF);
		rdchk(32'h5300_0020, 32'h0);
	endtask

	// Disabled counter holds; enabling keeps the written count
	task t_hold;
		wr(WDT_COUNT_ADDR, 32'h0123);
		wr(WDT_RELOAD_ADDR, 32'h0007);
		repeat (200) @(posedge clock);
		rdchk(WDT_COUNT_ADDR, 32'h0123);
		wr(WDT_CTRL_ADDR, 32'h0020);
		rdchk(WDT_COUNT_ADDR, 32'h0123);
		wr(WDT_CTRL_ADDR, 32'h0);
	endtask

	// Reload of one gives a time-out on every tick: pulse spacing is the tick period
	task t_div;
		for (int d = 0; d < 4; d++) begin
			wr(WDT_COUNT_ADDR, 32'h1);
			wr(WDT_RELOAD_ADDR, 32'h1);
			wr(WDT_CTRL_ADDR, 32'h0124 | (d << 3));
			wait_pulse();
			wait_pulse();
			chk(32'(n), 32'(32 << d));
			chk({31'h0, sys_reset}, 32'h0);
			wr(WDT_CTRL_ADDR, 32'h0);
		end
	endtask

	task t_irq;
		wr(WDT_IRQ_MASK_ADDR, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		rdchk(WDT_IRQ_STAT_ADDR, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		rdchk(WDT_IRQ_STAT_ADDR, 32'h0);
		wr(WDT_IRQ_MASK_ADDR, 32'h0);
	endtask

	task t_debug;
		debug_acknowledge <= 1'h1;
		wr(WDT_COUNT_ADDR, 32'h1);
		wr(WDT_RELOAD_ADDR, 32'h40);
		wr(WDT_CTRL_ADDR, 32'h0025);
		wait_pulse();
		@(posedge clock);
		chk({31'h0, sys_reset}, 32'h0);
		rdchk(WDT_COUNT_ADDR, 32'h40);
		rdchk(WDT_IRQ_STAT_ADDR, 32'h1);
		wr(WDT_CTRL_ADDR, 32'h0);
		debug_acknowledge <= 1'h0;
	endtask

	task t_rst;
		wr(WDT_COUNT_ADDR, 32'h1);
		wr(WDT_CTRL_ADDR, 32'h0025);
		wait_pulse();
		n = 0;
		while (sys_reset === 1'h1 && n < 300) begin
			n++;
			@(posedge clock);
		end
		chk(32'(n), 32'(WDT_RST_CYCLES));
		rdchk(WDT_IRQ_STAT_ADDR, 32'h3);
		wr(WDT_CTRL_ADDR, 32'h0);
	endtask

	task end_of_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#300000;
		$display("CHECK FAILED %0t: run did not finish", $time);
		error_cnt++;
		end_of_test();
	end

	initial begin
		rst_n = 1'h0;
		hsel = 1'h0;
		hwrite = 1'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		debug_acknowledge = 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		t_reset_vals();
		t_regs();
		t_hold();
		t_div();
		t_irq();
		t_debug();
		t_rst();
		end_of_test();
	end
endmodule
`default_nettype wire

// ### wdt_pkg.sv
// Package with register map, field layout and timing constants of the watchdog interval timer
package wdt_pkg;
	localparam logic [31:0] WDT_CTRL_ADDR = 32'h5300_0000;
	localparam logic [31:0] WDT_RELOAD_ADDR = 32'h5300_0004;
	localparam logic [31:0] WDT_COUNT_ADDR = 32'h5300_0008;
	localparam logic [31:0] WDT_IRQ_STAT_ADDR = 32'h5300_000C;
	localparam logic [31:0] WDT_IRQ_MASK_ADDR = 32'h5300_0010;
	localparam logic [7:0] WDT_BLOCK_BASE = 8'h53;
	localparam int WDT_PRESC_MSB = 15;
	localparam int WDT_PRESC_LSB = 8;
	localparam int WDT_EN_BIT = 5;
	localparam int WDT_DIV_MSB = 4;
	localparam int WDT_DIV_LSB = 3;
	localparam int WDT_IRQ_EN_BIT = 2;
	localparam int WDT_RST_EN_BIT = 0;
	localparam logic [15:0] WDT_CTRL_RESET = 16'h8021;
	localparam logic [15:0] WDT_CTRL_WMASK = 16'hFF3D;
	localparam logic [15:0] WDT_RELOAD_RESET = 16'h8000;
	localparam logic [15:0] WDT_COUNT_RESET = 16'h8000;
	localparam int WDT_RST_CYCLES = 128;
	localparam int WDT_STAT_TIMEOUT = 0;
	localparam int WDT_STAT_RESET = 1;
	localparam int WDT_STAT_W = 2;
endpackage

// ### wdt_tick_gen.sv
// Prescaler and selectable divider that make the count tick from the bus clock
`timescale 1ns/10ps
`default_nettype none
module wdt_tick_gen
	import wdt_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [7:0] presc,
	input wire logic [1:0] div_sel,
	output logic tick
);
	logic [7:0] presc_q;
	logic [6:0] div_q;
	logic presc_wrap;
	logic div_wrap;

	assign presc_wrap = (presc_q >= presc);
	always_comb begin
		case (div_sel)
			2'h0: div_wrap = (div_q[3:0] == 4'hF);
			2'h1: div_wrap = (div_q[4:0] == 5'h1F);
			2'h2: div_wrap = (div_q[5:0] == 6'h3F);
			default: div_wrap = (div_q == 7'h7F);
		endcase
	end

	// Divide by prescaler plus one, then by 16/32/64/128; idle while stopped
	always_ff @(posedge clock) begin
		if (!rst_n || !run) begin
			presc_q <= 8'h00;
			div_q <= 7'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (presc_wrap) begin
				presc_q <= 8'h00;
				div_q <= div_wrap ? 7'h00 : div_q + 7'h01;
				tick <= div_wrap;
			end else begin
				presc_q <= presc_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### wdt_top.sv
// Watchdog interval timer with AHB-Lite register slave
// Function
// - Time-out with reset enabled drives system reset for exactly 128 clocks.
// - Tick comes only from bus clock: prescaler plus one, then divider.
// - Control bits 15:8 hold prescaler, any value, reset 0x80.
// - Control bits 4:3 select divide by 16, 32, 64 or 128.
// - Control bit 5 enables counting; it is set after reset.
// - Control bit 2 enables interrupt request at each time-out; reset 0.
// - Control bit 0 lets time-out assert system reset; reset 1.
// - Enabling never loads reload into counter; software preloads the count.
// - Each time-out copies the reload value into the counter, unless a count write lands in the same cycle.
// - Reload and counter both reset to 0x8000.
// - Debug acknowledge keeps the reset output inactive.
// - Count register reads live counter and a write loads it.
// - Reload register is 16-bit read/write time-out period.
`timescale 1ns/10ps
`default_nettype none
module wdt_top
	import wdt_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic debug_acknowledge,
	output logic sys_reset,
	output logic timer_irq_pulse,
	output logic irq
);
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic [15:0] ctrl_q;
	logic [15:0] reload_q;
	logic [15:0] count_q;
	logic [WDT_STAT_W-1:0] stat_q;
	logic [WDT_STAT_W-1:0] mask_q;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic addr_ok;
	logic rd_take;
	logic wr_ctrl, wr_reload, wr_count, wr_mask;
	logic rd_stat;
	logic [31:0] rd_d;

	assign addr_ok = hsel && hready && htrans[1];
	assign rd_take = addr_ok && !hwrite;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok && hwrite)
				wr_addr_q <= haddr;
		end
	end

	assign wr_ctrl = wr_pend_q && (wr_addr_q == WDT_CTRL_ADDR);
	assign wr_reload = wr_pend_q && (wr_addr_q == WDT_RELOAD_ADDR);
	assign wr_count = wr_pend_q && (wr_addr_q == WDT_COUNT_ADDR);
	assign wr_mask = wr_pend_q && (wr_addr_q == WDT_IRQ_MASK_ADDR);
	assign rd_stat = rd_take && (haddr == WDT_IRQ_STAT_ADDR);

	always_comb begin
		case (haddr)
			WDT_CTRL_ADDR: rd_d = {16'h0000, ctrl_q};
			WDT_RELOAD_ADDR: rd_d = {16'h0000, reload_q};
			WDT_COUNT_ADDR: rd_d = {16'h0000, count_q};
			WDT_IRQ_STAT_ADDR: rd_d = {30'h0000_0000, stat_q};
			WDT_IRQ_MASK_ADDR: rd_d = {30'h0000_0000, mask_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Zero-wait slave: read data registered at the address phase edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_take)
				hrdata <= rd_d;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n)
			ctrl_q <= WDT_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= hwdata[15:0] & WDT_CTRL_WMASK;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			reload_q <= WDT_RELOAD_RESET;
		else if (wr_reload)
			reload_q <= hwdata[15:0];
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			mask_q <= {WDT_STAT_W{1'b0}};
		else if (wr_mask)
			mask_q <= hwdata[WDT_STAT_W-1:0];
	end

	// ----------------------------------------
	// Tick and down-counter
	// ----------------------------------------
	logic run;
	logic tick;
	logic timeout;

	assign run = ctrl_q[WDT_EN_BIT];

	wdt_tick_gen u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.run(run),
		.presc(ctrl_q[WDT_PRESC_MSB:WDT_PRESC_LSB]),
		.div_sel(ctrl_q[WDT_DIV_MSB:WDT_DIV_LSB]),
		.tick(tick)
	);

	assign timeout = run && tick && (count_q == 16'h0001 || count_q == 16'h0000);

	// Software load wins over the tick; enabling alone never loads
	always_ff @(posedge clock) begin
		if (!rst_n)
			count_q <= WDT_COUNT_RESET;
		else if (wr_count)
			count_q <= hwdata[15:0];
		else if (timeout)
			count_q <= reload_q;
		else if (run && tick)
			count_q <= count_q - 16'h0001;
	end

	// ----------------------------------------
	// Reset output and interrupt pulse
	// ----------------------------------------
	logic [7:0] rst_cnt_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rst_cnt_q <= 8'h00;
			sys_reset <= 1'b0;
		end else if (debug_acknowledge) begin
			rst_cnt_q <= 8'h00;
			sys_reset <= 1'b0;
		end else if (timeout && ctrl_q[WDT_RST_EN_BIT] && !sys_reset) begin
			rst_cnt_q <= 8'(WDT_RST_CYCLES - 1);
			sys_reset <= 1'b1;
		end else if (rst_cnt_q != 8'h00) begin
			rst_cnt_q <= rst_cnt_q - 8'h01;
		end else begin
			sys_reset <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			timer_irq_pulse <= 1'b0;
		else
			timer_irq_pulse <= timeout && ctrl_q[WDT_IRQ_EN_BIT];
	end

	// ----------------------------------------
	// Sticky status and interrupt line
	// ----------------------------------------
	logic [WDT_STAT_W-1:0] stat_set;

	assign stat_set[WDT_STAT_TIMEOUT] = timeout && ctrl_q[WDT_IRQ_EN_BIT];
	assign stat_set[WDT_STAT_RESET] = timeout && ctrl_q[WDT_RST_EN_BIT] && !debug_acknowledge;

	// Set wins over the clear caused by a read
	always_ff @(posedge clock) begin
		if (!rst_n)
			stat_q <= {WDT_STAT_W{1'b0}};
		else
			stat_q <= (rd_stat ? {WDT_STAT_W{1'b0}} : stat_q) | stat_set;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(((rd_stat ? {WDT_STAT_W{1'b0}} : stat_q) | stat_set) & mask_q);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [8:0] rst_len_q;
	always_ff @(posedge clock) begin
		if (!rst_n || !sys_reset)
			rst_len_q <= 9'h000;
		else
			rst_len_q <= rst_len_q + 9'h001;
	end

	logic [16:0] tick_gap_q;
	logic [16:0] tick_per;
	logic tick_seen_q;

	// Cycles between two ticks, judged only when the setting stayed put
	assign tick_per = ({9'h000, ctrl_q[WDT_PRESC_MSB:WDT_PRESC_LSB]} + 17'h00001)
		<< (3'h4 + {1'b0, ctrl_q[WDT_DIV_MSB:WDT_DIV_LSB]});

	always_ff @(posedge clock) begin
		if (!rst_n || !run || tick)
			tick_gap_q <= 17'h00000;
		else
			tick_gap_q <= tick_gap_q + 17'h00001;
	end

	always_ff @(posedge clock) begin
		if (!rst_n || !run || wr_ctrl)
			tick_seen_q <= 1'b0;
		else if (tick)
			tick_seen_q <= 1'b1;
	end

	reset_length_a: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(sys_reset) && !$past(debug_acknowledge) |-> rst_len_q
		== 9'(WDT_RST_CYCLES))
		else $error("reset pulse length not 128");
	reset_never_long_a: assert property (@(posedge clock) disable iff (!rst_n)
		rst_len_q <= 9'(WDT_RST_CYCLES))
		else $error("reset pulse too long");
	reset_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		timeout && ctrl_q[WDT_RST_EN_BIT] && !debug_acknowledge && !sys_reset
		|=> sys_reset)
		else $error("time-out did not start reset");
	reset_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(sys_reset) |-> $past(timeout) && $past(ctrl_q[WDT_RST_EN_BIT]))
		else $error("reset without enabled time-out");
	debug_block_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(debug_acknowledge) |-> !sys_reset)
		else $error("reset active during debug");
	reload_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
		timeout && !wr_count |=> count_q == $past(reload_q))
		else $error("reload not copied at time-out");
	count_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!run && !wr_count |=> count_q == $past(count_q) && !tick)
		else $error("counter moved while disabled");
	count_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
		run && tick && !timeout && !wr_count |=> count_q == $past(count_q) - 16'h0001)
		else $error("counter did not decrement");
	irq_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		timer_irq_pulse |-> $past(timeout) && $past(ctrl_q[WDT_IRQ_EN_BIT])
		##1 !timer_irq_pulse)
		else $error("interrupt pulse wrong");
	tick_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
		tick |=> !tick [*8])
		else $error("tick faster than divider allows");
	tick_period_a: assert property (@(posedge clock) disable iff (!rst_n)
		tick && tick_seen_q |-> tick_gap_q == tick_per - 17'h00001)
		else $error("tick period differs from prescaler and divider");
	tick_run_a: assert property (@(posedge clock) disable iff (!rst_n)
		tick |-> $past(run))
		else $error("tick while disabled");
	reset_values_a: assert property (@(posedge clock)
		!rst_n |=> count_q == WDT_COUNT_RESET && reload_q == WDT_RELOAD_RESET
		&& ctrl_q == WDT_CTRL_RESET && !sys_reset && !timer_irq_pulse && !irq)
		else $error("state after reset wrong");
	ctrl_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_ctrl |=> ctrl_q == ($past(hwdata[15:0]) & WDT_CTRL_WMASK))
		else $error("control write not stored");
	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(ctrl_q & ~WDT_CTRL_WMASK) == 16'h0000)
		else $error("reserved control bit set");
	ctrl_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_take && haddr == WDT_CTRL_ADDR |=> hrdata == {16'h0000, $past(ctrl_q)})
		else $error("control read wrong");
	reload_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_reload |=> reload_q == $past(hwdata[15:0]))
		else $error("reload write not stored");
	reload_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_take && haddr == WDT_RELOAD_ADDR |=> hrdata == {16'h0000, $past(reload_q)})
		else $error("reload read wrong");
	count_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_count |=> count_q == $past(hwdata[15:0]))
		else $error("count write not stored");
	count_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_take && haddr == WDT_COUNT_ADDR |=> hrdata == {16'h0000, $past(count_q)})
		else $error("count read not live value");
	enable_no_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(run) && !wr_count |=> count_q == $past(count_q))
		else $error("enabling changed the count");
	irq_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		timeout && ctrl_q[WDT_IRQ_EN_BIT] |=> timer_irq_pulse)
		else $error("time-out without interrupt pulse");
	irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(timeout && ctrl_q[WDT_IRQ_EN_BIT]) |=> !timer_irq_pulse)
		else $error("interrupt pulse without enabled time-out");
	reset_gate_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_q[WDT_RST_EN_BIT] && !sys_reset |=> !sys_reset)
		else $error("reset raised while reset function off");
	reset_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		sys_reset && !debug_acknowledge && rst_len_q != 9'(WDT_RST_CYCLES - 1)
		|=> sys_reset)
		else $error("reset pulse ended early");
	no_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
		sys_reset && rst_cnt_q != 8'h00 && !debug_acknowledge
		|=> rst_cnt_q == $past(rst_cnt_q) - 8'h01)
		else $error("reset pulse restarted");
	debug_cancel_a: assert property (@(posedge clock) disable iff (!rst_n)
		debug_acknowledge |=> rst_cnt_q == 8'h00)
		else $error("reset count kept during debug");
	stat_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_stat |=> stat_q == $past(stat_set))
		else $error("status not cleared by read");
	stat_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_stat |=> (stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status bit lost without read");
	stat_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_stat |=> hrdata == {30'h0000_0000, $past(stat_q)})
		else $error("status read wrong");
	reset_status_a: assert property (@(posedge clock) disable iff (!rst_n)
		timeout && ctrl_q[WDT_RST_EN_BIT] && !debug_acknowledge |=> stat_q[WDT_STAT_RESET])
		else $error("reset event not recorded");
	mask_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_mask |=> mask_q == $past(hwdata[WDT_STAT_W-1:0]))
		else $error("mask write not stored");
	irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_mask |=> irq == |(stat_q & mask_q))
		else $error("interrupt line differs from masked status");
endmodule
`default_nettype wire
